//--- test/enhanced_serial_port_chk.sv
// Port-level timing checker for the enhanced serial port
`timescale 1ns/10ps
module enhanced_serial_port_chk (
  input wire clk_sys_in,
  input wire reset_in,
  input wire clk_en_in,
  input wire [7:0] sfr_addr_in,
  input wire sfr_wr_in,
  input wire sfr_rd_in,
  input wire [7:0] sfr_wdata_in,
  input wire [7:0] sfr_rdata_out,
  input wire error_bit_select_in,
  input wire baud_double_in,
  input wire receive_pin_oe_n_out,
  input wire transmit_pin_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  // ----------------
  // Mode shadow
  // ----------------
  // Bit 7 only lands while it is not the error flag
  reg [1:0] mode_r;
  wire rd_go = sfr_rd_in && clk_en_in;
  wire buf_wr = sfr_wr_in && clk_en_in && sfr_addr_in == 8'h99;
  always @(posedge clk_sys_in) begin
    if (reset_in) begin
      mode_r <= 2'h0;
    end else if (sfr_wr_in && clk_en_in && sfr_addr_in == 8'h98) begin
      mode_r <= {error_bit_select_in ? mode_r[1] : sfr_wdata_in[7], sfr_wdata_in[6]};
    end
  end
  // ----------------
  // Assertions
  // ----------------
  a_unmapped_read_zero: assert property (
    rd_go && sfr_addr_in != 8'h98 && sfr_addr_in != 8'h99 |=> sfr_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!rd_go |=> $stable(sfr_rdata_out))
    else $error("read data moved without a read");
  a_read_mode_bits: assert property (
    rd_go && !sfr_wr_in && sfr_addr_in == 8'h98 && !error_bit_select_in
    |=> sfr_rdata_out[7:6] == mode_r) else $error("mode bits read wrong");
  a_write_starts_tx: assert property (
    buf_wr && mode_r != 2'h0 |-> ##[1:2] !transmit_pin_out) else $error("no start bit");
  a_mode2_fast_bit: assert property (
    mode_r == 2'h2 && baud_double_in && $fell(transmit_pin_out)
    |-> (!transmit_pin_out)[*8] ##1 (!transmit_pin_out)[*8]) else $error("bit under 16");
  a_mode2_slow_bit: assert property (
    mode_r == 2'h2 && !baud_double_in && $fell(transmit_pin_out)
    |-> ##31 !transmit_pin_out) else $error("bit under 32");
  a_mode0_clock_shape: assert property (
    mode_r == 2'h0 && $fell(transmit_pin_out)
    |-> (!transmit_pin_out)[*3] ##1 transmit_pin_out[*3]) else $error("shift clock shape");
  a_drive_mode0_only: assert property (
    !receive_pin_oe_n_out |-> mode_r == 2'h0) else $error("data pin driven in async");
  a_mode0_write_drives: assert property (
    buf_wr && mode_r == 2'h0 |-> ##[1:8] !receive_pin_oe_n_out) else $error("no mode0 tx");
  a_mode0_byte_length: assert property (
    mode_r == 2'h0 && $fell(receive_pin_oe_n_out)
    |-> ##40 !receive_pin_oe_n_out ##[1:14] receive_pin_oe_n_out) else $error("mode0 length");
endmodule // enhanced_serial_port_chk
bind enhanced_serial_port enhanced_serial_port_chk chk (.clk_sys_in(clk_sys_in),
  .reset_in(reset_in), .clk_en_in(clk_en_in), .sfr_addr_in(sfr_addr_in),
  .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in),
  .sfr_rdata_out(sfr_rdata_out), .error_bit_select_in(error_bit_select_in),
  .baud_double_in(baud_double_in), .receive_pin_oe_n_out(receive_pin_oe_n_out),
  .transmit_pin_out(transmit_pin_out));

//--- test/enhanced_serial_port_tb_top.sv
// Self-checking bench for the enhanced serial port
`timescale 1ns/10ps
module enhanced_serial_port_tb_top;
  // ----------------
  // Stimulus and wiring
  // ----------------
  localparam int K = 3;
  logic clk = 0, rst = 1, wr = 0, rd = 0, ebs = 0, dbl = 0, ovf = 0;
  logic [7:0] addr = 0, wd = 0, v;
  logic [31:0] seed = 9;
  int fail_count = 0, tests_run = 0, ovc = 0;
  wire [7:0] rdat;
  wire rxo, oen, txo, peer_line;
  // Resolved data pin: the design wins only while it drives
  wire rxd = oen ? peer_line : rxo;
  initial forever #50 clk = ~clk;
  // Baud timer stand-in, one overflow pulse every K clocks
  // It raises no timer interrupt while pacing the port
  always @(posedge clk) begin
    ovc <= (ovc == K - 1) ? 0 : ovc + 1;
    ovf <= (ovc == K - 1);
  end
  enhanced_serial_port dut (.clk_sys_in(clk), .reset_in(rst), .clk_en_in(1'b1),
    .sfr_addr_in(addr), .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_wdata_in(wd),
    .sfr_rdata_out(rdat), .error_bit_select_in(ebs), .baud_double_in(dbl),
    .baud_timer_overflow_in(ovf), .receive_pin_in(rxd), .receive_pin_out(rxo),
    .receive_pin_oe_n_out(oen), .transmit_pin_out(txo));
  serial_peer peer (.clk_in(clk), .txd_in(txo), .line_in(rxd), .line_out(peer_line));
  // ----------------
  // Helpers
  // ----------------
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) begin
      addr <= a;
      wd <= d;
      wr <= 1'b1;
    end
    @(posedge clk) wr <= 1'b0;
  endtask
  task rreg(input logic [7:0] a);
    @(posedge clk) begin
      addr <= a;
      rd <= 1'b1;
    end
    @(posedge clk) rd <= 1'b0;
    #1 v = rdat;
  endtask
  // Polls a control flag; hardware never clears it, so polling is safe
  task wflag(input int b);
    int i;
    for (i = 0; i < 3000; i++) begin
      rreg(8'h98);
      if (v[b] === 1'b1) break;
    end
    if (i == 3000) begin
      fail_count++;
      results();
    end
  endtask
  task results();
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Full duplex frame in each direction; model builds both frames
  task automatic async(input logic [1:0] m, input logic d2, input logic mp);
    logic [10:0] got, f, txf;
    logic [7:0] td, rdd;
    logic n9, t9;
    int n, p;
    {t9, n9, rdd, td} = 18'(rnd());
    n = (m == 2'h1) ? 10 : 11;
    p = (m == 2'h2) ? (d2 ? 16 : 32) : 16 * K * (d2 ? 1 : 2);
    @(posedge clk) dbl <= d2;
    wreg(8'h98, {m, mp, 1'b1, t9, 3'h0});
    wreg(8'h99, td);
    f = (m == 2'h1) ? {2'h3, rdd, 1'b0} : {1'b1, n9, rdd, 1'b0};
    txf = (m == 2'h1) ? {2'h3, td, 1'b0} : {1'b1, t9, td, 1'b0};
    fork
      peer.recv(n, p, got);
      peer.send(f, n, p);
    join
    chk(got, txf);
    wflag(1);
    if (mp && m != 2'h1 && !n9) begin
      rreg(8'h98);
      chk(v[0], 1'b0);
    end else begin
      wflag(0);
      rreg(8'h99);
      chk(v, rdd);
      rreg(8'h98);
      chk(v[2], (m == 2'h1) ? 1'b1 : n9);
    end
    $display("test async mode %0d done", m);
  endtask
  // ----------------
  // Main sequence
  // ----------------
  initial begin
    logic [7:0] a, b;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rreg(8'h98);
    chk(v, 8'h00);
    rreg(8'h9a);
    chk(v, 8'h00);
    wreg(8'h98, 8'hf8);
    rreg(8'h98);
    chk(v, 8'hf8);
    $display("test registers done");
    {a, b} = 16'(rnd());
    wreg(8'h98, 8'h00);
    wreg(8'h99, a);
    peer.srecv(v);
    chk(v, a);
    wflag(1);
    wreg(8'h98, 8'h10);
    peer.ssend(b);
    wflag(0);
    rreg(8'h99);
    chk(v, b);
    wreg(8'h98, 8'h00);
    $display("test mode 0 done");
    for (int c = 0; c < 6; c++) async(2'(c % 3 + 1), c < 3, c > 2);
    wreg(8'h98, 8'h50);
    @(posedge clk) dbl <= 1'b1;
    {a, b} = 16'(rnd());
    peer.send({2'h0, a, 1'b0}, 10, 16 * K);
    peer.send({2'h3, b, 1'b0}, 10, 16 * K);
    @(posedge clk) ebs <= 1'b1;
    rreg(8'h98);
    chk(v[7], 1'b1);
    rreg(8'h99);
    chk(v, b);
    wreg(8'h98, 8'h50);
    rreg(8'h98);
    chk(v[7], 1'b0);
    @(posedge clk) ebs <= 1'b0;
    rreg(8'h98);
    chk(v[7:6], 2'h1);
    $display("test framing error done");
    results();
  end
endmodule // enhanced_serial_port_tb_top

//--- test/serial_peer.sv
// Remote serial device on the receive and transmit pins
`timescale 1ns/10ps
module serial_peer (
  input wire clk_in,
  input wire txd_in,
  input wire line_in,
  output reg line_out
);
  // ----------------
  // Line drivers
  // ----------------
  initial line_out = 1'b1;
  // Acts 1 ns after the edge so the design's edge has landed
  task tick();
    @(posedge clk_in);
    #1;
  endtask
  task automatic wlev(input logic l);
    int k = 0;
    while (txd_in !== l && k < 100) begin
      tick();
      k++;
    end
  endtask
  // Async frame LSB first, then one idle bit high
  task automatic send(input logic [10:0] f, input int n, input int p);
    #1;
    for (int i = 0; i < n; i++) begin
      line_out = f[i];
      repeat (p) tick();
    end
    line_out = 1'b1;
    repeat (p) tick();
  endtask
  // Mid-bit sampling; unknown result if no start bit shows
  task automatic recv(input int n, input int p, output logic [10:0] f);
    int k = 0;
    f = 11'h7ff;
    while (txd_in !== 1'b0 && k < 400) begin
      tick();
      k++;
    end
    if (k == 400) f = 'x;
    else begin
      repeat (p / 2) tick();
      for (int i = 0; i < n; i++) begin
        f[i] = txd_in;
        repeat (p) tick();
      end
    end
  endtask
  // Mode 0: new bit at each falling shift clock, then let go
  task automatic ssend(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      wlev(1'b0);
      line_out = d[i];
      wlev(1'b1);
    end
    line_out = ~d[7];
    // Inverse for one bit, then back to the idle high of the async line
    repeat (6) tick();
    line_out = 1'b1;
  endtask
  task automatic srecv(output logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      wlev(1'b0);
      wlev(1'b1);
      d[i] = line_in;
    end
  endtask
endmodule // serial_peer

//--- verilog/enhanced_serial_port.v
// Enhanced full-duplex serial port with four modes and a control register
//
// Notes on behaviour
// R1: Outside mode 0 transmit and receive run together; a second receive overwrites an unread byte.
// R2: Buffer writes load transmit data; buffer reads return a separate receive register.
// R3: Mode 0 moves data on receive pin, clock on transmit pin, 8 bits, clk/6.
// R4: Mode 1 sends start, eight data LSB first, stop; stop bit kept as ninth.
// R5: Modes 2 and 3 send eleven bits; received ninth bit kept, stop ignored (the code still checks it to set the framing error flag).
// R6: Transmitted ninth bit in modes 2 and 3 comes from transmit_ninth_bit.
// R7: Mode 2 rate is clock/32, or clock/16 when baud_double is set.
// R8: Mode 3 equals mode 2 except its rate comes from the baud timer.
// R9: Any write to the buffer starts a transmission in every mode.
// R10: Mode 0 receives when enabled and done flag clear; others on start bit.
// R11: Mode select bits pick shift, 8-bit variable, 9-bit fixed, 9-bit variable.
// R12: Control bit 7 is mode_select_high or framing error per error_bit_select.
// R13: Framing error sets on missing stop bit and stays until software clears.
// R14: Framing error detection and address recognition are provided.
// R15: Modes 1 and 3 derive bit rate from timer overflow, halved unless doubled.
// R16: Any overflow pulse of the baud timer, whatever its mode, drives the rate.
// R17: Software should keep the baud timer interrupt disabled meanwhile.
// R18: With multiprocessor_enable in modes 2 and 3, ninth bit 0 sets no flag.
// R19: Done flags set by hardware at frame end; only software clears them.
`timescale 1ns/10ps
`include "enhanced_serial_port_consts.vh"

module enhanced_serial_port (
  input wire clk_sys_in,
  input wire reset_in,
  input wire clk_en_in,
  input wire [7:0] sfr_addr_in,
  input wire sfr_wr_in,
  input wire sfr_rd_in,
  input wire [7:0] sfr_wdata_in,
  output reg [7:0] sfr_rdata_out,
  input wire error_bit_select_in,
  input wire baud_double_in,
  input wire baud_timer_overflow_in,
  input wire receive_pin_in,
  output reg receive_pin_out,
  output reg receive_pin_oe_n_out,
  output reg transmit_pin_out
);

  // ----------------------------------------------------------------
  // State codes
  // ----------------------------------------------------------------
  localparam TX_IDLE = 2'd0;
  localparam TX_ASYNC = 2'd1;
  localparam TX_SHIFT = 2'd2;
  localparam RX_IDLE = 2'd0;
  localparam RX_START = 2'd1;
  localparam RX_DATA = 2'd2;
  localparam RX_SHIFT = 2'd3;

  // Compares an address with a register address
  function hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  // ----------------------------------------------------------------
  // Control register bits and data registers
  // ----------------------------------------------------------------
  reg mode_select_high_r;
  reg mode_select_low_r;
  reg multiprocessor_enable_r;
  reg receive_enable_bit_r;
  reg transmit_ninth_bit_r;
  reg received_ninth_bit_r;
  reg transmit_done_flag_r;
  reg receive_done_flag_r;
  reg framing_error_flag_r;
  reg [7:0] receive_buffer_r;
  reg div2_r;
  reg overflow_half_r;
  reg rx_prev_r;

  reg [1:0] tx_state_r;
  reg [10:0] tx_shift_r;
  reg [3:0] tx_left_r;
  reg [3:0] tx_phase_r;
  reg tx_bit_r;

  reg [1:0] rx_state_r;
  reg [9:0] rx_shift_r;
  reg [3:0] rx_left_r;
  reg [3:0] rx_phase_r;

  wire [1:0] mode = {mode_select_high_r, mode_select_low_r}; // see R11
  wire write_control = sfr_wr_in && hit(sfr_addr_in, `ADDR_SERIAL_PORT_CONTROL);
  wire write_buffer = sfr_wr_in && hit(sfr_addr_in, `ADDR_SERIAL_BUFFER);

  // ----------------------------------------------------------------
  // Sixteen-times bit rate tick
  // ----------------------------------------------------------------
  // Mode 2 ticks at clk/2 or clk; variable modes use every second overflow
  // unless doubled, which gives clk/32 or clk/16 over the reload span.
  wire sample_tick = (mode == `MODE_9BIT_FIXED) ? (baud_double_in | div2_r) : // see R7
                     (baud_double_in ? baud_timer_overflow_in :
                      (baud_timer_overflow_in & overflow_half_r)); // see R15 see R16 see R8

  always @(posedge clk_sys_in) begin
    if (reset_in) begin
      div2_r <= 1'b0;
      overflow_half_r <= 1'b0;
      rx_prev_r <= 1'b1;
    end else if (clk_en_in) begin
      // Mode 2 write restarts the divider so the start bit is a full bit;
      // a frame being received at that moment slips by one clock at most
      if (write_buffer && mode == `MODE_9BIT_FIXED)
        div2_r <= 1'b0;
      else
        div2_r <= ~div2_r;
      if (baud_timer_overflow_in)
        overflow_half_r <= ~overflow_half_r;
      rx_prev_r <= receive_pin_in;
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  wire tx_finish_async = (tx_state_r == TX_ASYNC) && sample_tick &&
                         (tx_phase_r == `TICK_LAST) && (tx_left_r == 4'd1);
  wire tx_finish_shift = (tx_state_r == TX_SHIFT) &&
                         (tx_phase_r == `SHIFT_CLK_LAST) && (tx_left_r == 4'd1);

  // A write while busy restarts the frame; the old one is abandoned
  always @(posedge clk_sys_in) begin
    if (reset_in) begin
      tx_state_r <= TX_IDLE;
      tx_shift_r <= 11'h7ff;
      tx_left_r <= 4'h0;
      tx_phase_r <= 4'h0;
      tx_bit_r <= 1'b1;
    end else if (clk_en_in) begin
      if (write_buffer) begin // see R9 see R2
        tx_phase_r <= 4'h0;
        if (mode == `MODE_SHIFT) begin
          tx_state_r <= TX_SHIFT; // see R3
          tx_shift_r <= {3'b111, sfr_wdata_in};
          tx_left_r <= `SHIFT_DATA_BITS;
          tx_bit_r <= sfr_wdata_in[0];
        end else if (mode == `MODE_8BIT_VAR) begin
          tx_state_r <= TX_ASYNC;
          tx_shift_r <= {2'b11, sfr_wdata_in, 1'b0}; // see R4
          tx_left_r <= `FRAME_BITS_8BIT;
          tx_bit_r <= 1'b0;
        end else begin
          tx_state_r <= TX_ASYNC;
          tx_shift_r <= {1'b1, transmit_ninth_bit_r, sfr_wdata_in, 1'b0}; // see R5 see R6
          tx_left_r <= `FRAME_BITS_9BIT;
          tx_bit_r <= 1'b0;
        end
      end else begin
        case (tx_state_r)
          TX_ASYNC: begin
            if (sample_tick) begin
              tx_phase_r <= tx_phase_r + 4'd1;
              if (tx_phase_r == `TICK_LAST) begin
                if (tx_left_r == 4'd1) begin
                  tx_state_r <= TX_IDLE;
                  tx_bit_r <= 1'b1;
                end else begin
                  tx_shift_r <= {1'b1, tx_shift_r[10:1]};
                  tx_bit_r <= tx_shift_r[1];
                end
                tx_left_r <= tx_left_r - 4'd1;
              end
            end
          end
          TX_SHIFT: begin
            if (tx_phase_r == `SHIFT_CLK_LAST) begin
              tx_phase_r <= 4'h0;
              tx_left_r <= tx_left_r - 4'd1;
              if (tx_left_r == 4'd1) begin
                tx_state_r <= TX_IDLE;
              end else begin
                tx_shift_r <= {1'b1, tx_shift_r[10:1]};
                tx_bit_r <= tx_shift_r[1];
              end
            end else begin
              tx_phase_r <= tx_phase_r + 4'd1;
            end
          end
          default: begin
            tx_state_r <= TX_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  wire [9:0] rx_word = {receive_pin_in, rx_shift_r[9:1]};
  wire rx_async_last = (rx_state_r == RX_DATA) && sample_tick &&
                       (rx_phase_r == `TICK_LAST) && (rx_left_r == 4'd1);
  wire rx_shift_last = (rx_state_r == RX_SHIFT) &&
                       (rx_phase_r == `SHIFT_CLK_LAST) && (rx_left_r == 4'd1);
  wire rx_nine = (mode == `MODE_9BIT_FIXED) || (mode == `MODE_9BIT_VAR);
  // Address recognition: data frames with ninth bit 0 are dropped
  wire rx_accept = rx_nine ? (!multiprocessor_enable_r || rx_word[8]) : // see R18 see R14
                   (!multiprocessor_enable_r || rx_word[9]);
  wire rx_done_async = rx_async_last && rx_accept;
  wire rx_bad_stop = rx_async_last && !rx_word[9]; // see R13

  // Sampling at mid-start then every sixteen ticks centres each bit
  always @(posedge clk_sys_in) begin
    if (reset_in) begin
      rx_state_r <= RX_IDLE;
      rx_shift_r <= 10'h3ff;
      rx_left_r <= 4'h0;
      rx_phase_r <= 4'h0;
    end else if (clk_en_in) begin
      case (rx_state_r)
        RX_IDLE: begin
          rx_phase_r <= 4'h0;
          if (receive_enable_bit_r && mode == `MODE_SHIFT && !receive_done_flag_r &&
              tx_state_r == TX_IDLE && !write_buffer) begin
            rx_state_r <= RX_SHIFT; // see R10
            rx_left_r <= `SHIFT_DATA_BITS;
          end else if (receive_enable_bit_r && mode != `MODE_SHIFT &&
                       rx_prev_r && !receive_pin_in) begin
            rx_state_r <= RX_START; // see R10
          end
        end
        RX_START: begin
          if (sample_tick) begin
            rx_phase_r <= rx_phase_r + 4'd1;
            if (rx_phase_r == `START_MID_TICK) begin
              rx_phase_r <= 4'h0;
              if (receive_pin_in) begin
                rx_state_r <= RX_IDLE; // False start, glitch rejected
              end else begin
                rx_state_r <= RX_DATA;
                rx_left_r <= rx_nine ? 4'd10 : 4'd9;
              end
            end
          end
        end
        RX_DATA: begin
          if (sample_tick) begin
            rx_phase_r <= rx_phase_r + 4'd1;
            if (rx_phase_r == `TICK_LAST) begin
              rx_shift_r <= rx_word;
              rx_left_r <= rx_left_r - 4'd1;
              if (rx_left_r == 4'd1)
                rx_state_r <= RX_IDLE;
            end
          end
        end
        RX_SHIFT: begin
          if (rx_phase_r == `SHIFT_CLK_LAST) begin
            rx_phase_r <= 4'h0;
            rx_left_r <= rx_left_r - 4'd1;
            if (rx_left_r == 4'd1)
              rx_state_r <= RX_IDLE;
          end else begin
            rx_phase_r <= rx_phase_r + 4'd1;
          end
          if (rx_phase_r == `SHIFT_SAMPLE_PHASE)
            rx_shift_r <= rx_word; // see R3
        end
        default: begin
          rx_state_r <= RX_IDLE;
        end
      endcase
      if (!receive_enable_bit_r && rx_state_r != RX_SHIFT)
        rx_state_r <= RX_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Control register and receive buffer
  // ----------------------------------------------------------------
  // Hardware sets take priority over a software clear in the same cycle
  always @(posedge clk_sys_in) begin
    if (reset_in) begin
      mode_select_high_r <= 1'b0;
      mode_select_low_r <= 1'b0;
      multiprocessor_enable_r <= 1'b0;
      receive_enable_bit_r <= 1'b0;
      transmit_ninth_bit_r <= 1'b0;
      received_ninth_bit_r <= 1'b0;
      transmit_done_flag_r <= 1'b0;
      receive_done_flag_r <= 1'b0;
      framing_error_flag_r <= 1'b0;
      receive_buffer_r <= `BUFFER_RESET;
    end else if (clk_en_in) begin
      if (write_control) begin
        if (error_bit_select_in)
          framing_error_flag_r <= sfr_wdata_in[`BIT_MODE_HIGH_OR_FE]; // see R12
        else
          mode_select_high_r <= sfr_wdata_in[`BIT_MODE_HIGH_OR_FE];
        mode_select_low_r <= sfr_wdata_in[`BIT_MODE_LOW];
        multiprocessor_enable_r <= sfr_wdata_in[`BIT_MULTIPROC];
        receive_enable_bit_r <= sfr_wdata_in[`BIT_RX_ENABLE];
        transmit_ninth_bit_r <= sfr_wdata_in[`BIT_TX_NINTH];
        received_ninth_bit_r <= sfr_wdata_in[`BIT_RX_NINTH];
        transmit_done_flag_r <= sfr_wdata_in[`BIT_TX_DONE];
        receive_done_flag_r <= sfr_wdata_in[`BIT_RX_DONE];
      end
      if (tx_finish_async || tx_finish_shift)
        transmit_done_flag_r <= 1'b1; // see R19
      // Unread byte is overwritten: the buffer holds one finished frame
      if (rx_done_async) begin
        receive_buffer_r <= rx_nine ? rx_word[7:0] : rx_word[8:1]; // see R1
        received_ninth_bit_r <= rx_nine ? rx_word[8] : rx_word[9]; // see R4 see R5
        receive_done_flag_r <= 1'b1; // see R19
      end
      if (rx_shift_last) begin
        receive_buffer_r <= rx_shift_r[9:2];
        receive_done_flag_r <= 1'b1; // see R19
      end
      if (rx_bad_stop)
        framing_error_flag_r <= 1'b1; // see R13
    end
  end

  // ----------------------------------------------------------------
  // Read port and pins
  // ----------------------------------------------------------------
  // Read data is registered: it appears the cycle after the strobe
  always @(posedge clk_sys_in) begin
    if (reset_in) begin
      sfr_rdata_out <= 8'h00;
      transmit_pin_out <= 1'b1;
      receive_pin_out <= 1'b1;
      receive_pin_oe_n_out <= 1'b1;
    end else if (clk_en_in) begin
      if (sfr_rd_in && hit(sfr_addr_in, `ADDR_SERIAL_PORT_CONTROL))
        sfr_rdata_out <= {error_bit_select_in ? framing_error_flag_r : mode_select_high_r,
                          mode_select_low_r, multiprocessor_enable_r, receive_enable_bit_r,
                          transmit_ninth_bit_r, received_ninth_bit_r,
                          transmit_done_flag_r, receive_done_flag_r}; // see R12
      else if (sfr_rd_in && hit(sfr_addr_in, `ADDR_SERIAL_BUFFER))
        sfr_rdata_out <= receive_buffer_r; // see R2
      else if (sfr_rd_in)
        sfr_rdata_out <= 8'h00;
      // Shift clock low for the first half of each six-cycle bit
      if (tx_state_r == TX_SHIFT) begin
        transmit_pin_out <= (tx_phase_r >= `SHIFT_CLK_HIGH_PHASE); // see R3
        receive_pin_out <= tx_bit_r;
        receive_pin_oe_n_out <= 1'b0;
      end else if (rx_state_r == RX_SHIFT) begin
        transmit_pin_out <= (rx_phase_r >= `SHIFT_CLK_HIGH_PHASE);
        receive_pin_out <= 1'b1;
        receive_pin_oe_n_out <= 1'b1;
      end else begin
        transmit_pin_out <= (tx_state_r == TX_ASYNC) ? tx_bit_r : 1'b1;
        receive_pin_out <= 1'b1;
        receive_pin_oe_n_out <= 1'b1;
      end
    end
  end

endmodule // enhanced_serial_port

//--- verilog/enhanced_serial_port_consts.vh
// Constants for the enhanced serial port: addresses, bit fields, counts
`ifndef ENHANCED_SERIAL_PORT_CONSTS_VH
`define ENHANCED_SERIAL_PORT_CONSTS_VH

// ----------------------------------------------------------------
// Register addresses on the special function register port
// ----------------------------------------------------------------
`define ADDR_SERIAL_PORT_CONTROL 8'h98
`define ADDR_SERIAL_BUFFER 8'h99
`define CONTROL_RESET 8'h00
`define BUFFER_RESET 8'h00

// ----------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------
`define BIT_MODE_HIGH_OR_FE 7
`define BIT_MODE_LOW 6
`define BIT_MULTIPROC 5
`define BIT_RX_ENABLE 4
`define BIT_TX_NINTH 3
`define BIT_RX_NINTH 2
`define BIT_TX_DONE 1
`define BIT_RX_DONE 0

// ----------------------------------------------------------------
// Mode codes {mode_select_high, mode_select_low}
// ----------------------------------------------------------------
`define MODE_SHIFT 2'h0
`define MODE_8BIT_VAR 2'h1
`define MODE_9BIT_FIXED 2'h2
`define MODE_9BIT_VAR 2'h3

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define SHIFT_CLK_DIV 6
`define SHIFT_CLK_LAST 4'h5
`define SHIFT_CLK_HIGH_PHASE 4'h3
`define SHIFT_SAMPLE_PHASE 4'h2
`define TICKS_PER_BIT 16
`define TICK_LAST 4'hf
`define START_MID_TICK 4'h7
`define SHIFT_DATA_BITS 4'h8
`define FRAME_BITS_8BIT 4'ha
`define FRAME_BITS_9BIT 4'hb

`endif
